/* verilog/isa_pkg.sv */
// Purpose: Shared constants and types for the integer subtract/logic/shift datapath
// Assumes: 64-bit operands, 8-bit literal, one-cycle registered result
// Notes:   Operation codes are local to this block
package isa_pkg;
  localparam int unsigned   XLEN          = 64;
  localparam int unsigned   LIT_W         = 8;
  localparam int unsigned   CNT_W         = 6;
  localparam int unsigned   CNT_LSB       = 0;
  localparam int unsigned   WORD_MSB      = 31;
  localparam int unsigned   SCALE4_SH     = 2;
  localparam int unsigned   SCALE8_SH     = 3;
  localparam logic [63:0]   RESULT_RST    = 64'h0;
  localparam logic [4:0]    DEST_RST      = 5'h0;
  localparam int unsigned   LATENCY_CYC   = 1;

  typedef enum logic [4:0] {
    OP_MUL_UNSIGNED_UPPER_HALF,
    OP_SUB_LONG,
    OP_SCALED4_SUB_LONG,
    OP_SCALED8_SUB_LONG,
    OP_SUB_QUAD,
    OP_SCALED4_SUB_QUAD,
    OP_SCALED8_SUB_QUAD,
    OP_AND,
    OP_AND_COMPLEMENT,
    OP_INCLUSIVE_OR,
    OP_OR_COMPLEMENT,
    OP_XOR,
    OP_XNOR_OP,
    OP_COND_MOVE,
    OP_SHIFT_LEFT_ZERO_FILL,
    OP_SHIFT_RIGHT_ZERO_FILL,
    OP_SHIFT_RIGHT_SIGN_FILL
  } isa_op_t;

  typedef enum logic [2:0] {
    CND_EQ,
    CND_NE,
    CND_LT,
    CND_LE,
    CND_GT,
    CND_GE,
    CND_LBC,
    CND_LBS
  } isa_cond_t;
endpackage : isa_pkg

/* verilog/isa_shifter.sv */
// Purpose: 64-bit barrel shifter, left/right logical and right arithmetic
// Assumes: Count already limited to six bits by the caller
// Notes:   Purely combinational
`timescale 1ns/1ps
module isa_shifter (
  input  wire logic [63:0] value_i,
  input  wire logic [5:0]  count_i,
  input  wire logic        left_i,
  input  wire logic        arith_i,
  output logic      [63:0] result_o
);
  always_comb begin
    if (left_i) begin
      result_o = value_i << count_i;
    end else if (arith_i) begin
      result_o = $signed(value_i) >>> count_i;
    end else begin
      result_o = value_i >> count_i;
    end
  end
endmodule : isa_shifter

/* verilog/isa_alu.sv */
// Purpose: Integer subtract, multiply-high, Boolean, conditional move and shift datapath
// Assumes: One instruction per valid cycle; result registered one cycle later
// Notes:   Result, strobe and trap registered
// Function
// - Unsigned multiply-high writes upper 64 bits of the 128-bit product, no trap.
// - Longword subtract keeps low 32 bits of A minus B, sign-extended.
// - Longword overflow judged from the 32-bit low-half difference only.
// - Plain subtracts trap on overflow when enabled; scaled subtracts never trap.
// - Scaled longword subtract: A shifted by 2 or 3, minus B, sign-extended.
// - Quadword subtract writes the full 64-bit difference.
// - On quadword overflow the low 64 bits of the exact difference are written.
// - Scaled quadword subtract: A shifted by 2 or 3, minus B, no overflow.
// - Boolean AND, OR, XOR over all 64 bits.
// - Complemented variants invert B before AND, OR or XOR.
// - Conditional move writes B only when the test on A holds.
// - Tests: eq, ne, lt, le, gt, ge zero, low bit clear, low bit set.
// - Logical shifts by B low six bits, zeros fill.
// - Left logical, right logical, right arithmetic only; count from B low six bits.
// - Arithmetic right shift replicates bit 63 into vacated positions.
`timescale 1ns/1ps
module isa_alu (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                valid_i,
  input  wire isa_pkg::isa_op_t    op_i,
  input  wire isa_pkg::isa_cond_t  cond_i,
  input  wire logic                trap_en_i,
  input  wire logic                use_lit_i,
  input  wire logic [7:0]          literal_i,
  input  wire logic [63:0]         operand_a_i,
  input  wire logic [63:0]         operand_b_i,
  input  wire logic [4:0]          dest_i,
  output logic                     wr_en_o,
  output logic [4:0]               dest_o,
  output logic [63:0]              result_o,
  output logic                     ovf_trap_o
);
  logic [63:0]  b_val;
  logic [63:0]  shift_res;
  logic [127:0] prod;
  logic [63:0]  res_nxt;
  logic         wr_nxt;
  logic         trap_nxt;
  logic [63:0]  res_r;
  logic         wr_r;
  logic         trap_r;
  logic [4:0]   dest_r;
  logic [4:0]   dest_nxt;
  logic         cond_ok;
  logic [31:0]  dl;
  logic [31:0]  dsl;
  logic [63:0]  dq;
  logic [63:0]  a_scl;
  logic         ovf_l;
  logic         ovf_q;

  function automatic logic [63:0] sext32(input logic [31:0] v);
    sext32 = {{32{v[isa_pkg::WORD_MSB]}}, v};
  endfunction : sext32

  function automatic logic sub_ovf(input logic sa, input logic sb, input logic sd);
    sub_ovf = (sa != sb) && (sd != sa);
  endfunction : sub_ovf

  function automatic logic [63:0] scl(input logic [63:0] v, input logic eight);
    scl = eight ? (v << isa_pkg::SCALE8_SH) : (v << isa_pkg::SCALE4_SH);
  endfunction : scl

  // Literal widened with zeros
  assign b_val = use_lit_i ? {56'h0, literal_i} : operand_b_i;

  isa_shifter u_shift (
    .value_i  (operand_a_i),
    .count_i  (b_val[isa_pkg::CNT_W-1:isa_pkg::CNT_LSB]),
    .left_i   (op_i == isa_pkg::OP_SHIFT_LEFT_ZERO_FILL),
    .arith_i  (op_i == isa_pkg::OP_SHIFT_RIGHT_SIGN_FILL),
    .result_o (shift_res)
  );

  always_comb begin
    prod  = {64'h0, operand_a_i} * {64'h0, b_val};
    dl    = operand_a_i[31:0] - b_val[31:0];
    dq    = operand_a_i - b_val;
    a_scl = scl(operand_a_i, op_i == isa_pkg::OP_SCALED8_SUB_LONG
                || op_i == isa_pkg::OP_SCALED8_SUB_QUAD);
    dsl   = a_scl[31:0] - b_val[31:0];
    ovf_l = sub_ovf(operand_a_i[31], b_val[31], dl[31]);
    ovf_q = sub_ovf(operand_a_i[63], b_val[63], dq[63]);
    case (cond_i)
      isa_pkg::CND_EQ:  cond_ok = (operand_a_i == 64'h0);
      isa_pkg::CND_NE:  cond_ok = (operand_a_i != 64'h0);
      isa_pkg::CND_LT:  cond_ok = operand_a_i[63];
      isa_pkg::CND_LE:  cond_ok = operand_a_i[63] || (operand_a_i == 64'h0);
      isa_pkg::CND_GT:  cond_ok = !operand_a_i[63] && (operand_a_i != 64'h0);
      isa_pkg::CND_GE:  cond_ok = !operand_a_i[63];
      isa_pkg::CND_LBC: cond_ok = !operand_a_i[0];
      default:          cond_ok = operand_a_i[0];
    endcase
  end

  always_comb begin
    res_nxt  = res_r;
    wr_nxt   = 1'b0;
    trap_nxt = 1'b0;
    dest_nxt = dest_r;
    if (valid_i) begin
      wr_nxt = 1'b1;
      dest_nxt = dest_i;
      case (op_i)
        isa_pkg::OP_MUL_UNSIGNED_UPPER_HALF: begin
          res_nxt = prod[127:64];
        end
        isa_pkg::OP_SUB_LONG: begin
          res_nxt  = sext32(dl);
          trap_nxt = trap_en_i && ovf_l;
        end
        isa_pkg::OP_SCALED4_SUB_LONG,
        isa_pkg::OP_SCALED8_SUB_LONG: begin
          res_nxt = sext32(dsl);
        end
        isa_pkg::OP_SUB_QUAD: begin
          res_nxt  = dq;
          trap_nxt = trap_en_i && ovf_q;
        end
        isa_pkg::OP_SCALED4_SUB_QUAD,
        isa_pkg::OP_SCALED8_SUB_QUAD: begin
          res_nxt = a_scl - b_val;
        end
        isa_pkg::OP_AND:           res_nxt = operand_a_i & b_val;
        isa_pkg::OP_INCLUSIVE_OR:  res_nxt = operand_a_i | b_val;
        isa_pkg::OP_XOR:           res_nxt = operand_a_i ^ b_val;
        isa_pkg::OP_AND_COMPLEMENT: res_nxt = operand_a_i & ~b_val;
        isa_pkg::OP_OR_COMPLEMENT: res_nxt = operand_a_i | ~b_val;
        isa_pkg::OP_XNOR_OP:       res_nxt = operand_a_i ^ ~b_val;
        isa_pkg::OP_COND_MOVE: begin
          wr_nxt = cond_ok;
          if (cond_ok) begin
            res_nxt = b_val;
          end
        end
        isa_pkg::OP_SHIFT_LEFT_ZERO_FILL,
        isa_pkg::OP_SHIFT_RIGHT_ZERO_FILL,
        isa_pkg::OP_SHIFT_RIGHT_SIGN_FILL: begin
          res_nxt = shift_res;
        end
        default: begin
          wr_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_r  <= isa_pkg::RESULT_RST;
      wr_r   <= 1'b0;
      trap_r <= 1'b0;
      dest_r <= isa_pkg::DEST_RST;
    end else begin
      res_r  <= res_nxt;
      wr_r   <= wr_nxt;
      trap_r <= trap_nxt;
      dest_r <= dest_nxt;
    end
  end

  assign wr_en_o    = wr_r;
  assign dest_o     = dest_r;
  assign result_o   = res_r;
  assign ovf_trap_o = trap_r;

  sequence s_quad_issue;
    valid_i && (op_i == isa_pkg::OP_SUB_QUAD);
  endsequence

  sequence s_long_issue;
    valid_i && (op_i == isa_pkg::OP_SUB_LONG);
  endsequence

  sequence s_cmov_issue;
    valid_i && (op_i == isa_pkg::OP_COND_MOVE);
  endsequence

  sequence s_scaled_long_issue;
    valid_i && op_i inside {isa_pkg::OP_SCALED4_SUB_LONG, isa_pkg::OP_SCALED8_SUB_LONG};
  endsequence

  a_mulh_upper: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_MUL_UNSIGNED_UPPER_HALF
    |=> result_o == $past(prod[127:64]) && !ovf_trap_o)
    else $error("mul high result wrong");

  a_long_sext: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_long_issue |=> result_o[63:32] == {32{result_o[31]}}
      && result_o[31:0] == $past(operand_a_i[31:0] - b_val[31:0]))
    else $error("longword subtract result wrong");

  a_long_trap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_long_issue ##0 (trap_en_i && ovf_l) |=> ovf_trap_o)
    else $error("longword overflow trap missing");

  a_scaled_notrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i inside {isa_pkg::OP_SCALED4_SUB_LONG, isa_pkg::OP_SCALED8_SUB_LONG,
      isa_pkg::OP_SCALED4_SUB_QUAD, isa_pkg::OP_SCALED8_SUB_QUAD} |=> !ovf_trap_o)
    else $error("scaled subtract trapped");

  a_s8_quad: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SCALED8_SUB_QUAD
    |=> result_o == $past((operand_a_i << 3) - b_val))
    else $error("scaled by 8 quad subtract wrong");

  a_quad_ovf: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_quad_issue ##0 trap_en_i |=> ovf_trap_o ==
      $past((operand_a_i[63] != b_val[63]) && (dq[63] != operand_a_i[63])))
    else $error("quad overflow trap wrong");

  a_cmov_skip: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_COND_MOVE && !cond_ok |=> !wr_en_o && $stable(result_o))
    else $error("false conditional move wrote");

  a_sra_fill: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SHIFT_RIGHT_SIGN_FILL && operand_a_i[63]
      && b_val[5:0] == 6'h3f |=> result_o == 64'hffffffffffffffff)
    else $error("sign fill wrong");

  a_idle_nowrite: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !valid_i |=> !wr_en_o && !ovf_trap_o)
    else $error("write without issue");

  a_scl_long_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_scaled_long_issue |=> result_o[63:32] == {32{result_o[31]}} && result_o[31:0] ==
      $past((op_i == isa_pkg::OP_SCALED8_SUB_LONG ? {operand_a_i[28:0], 3'h0}
      : {operand_a_i[29:0], 2'h0}) - b_val[31:0]))
    else $error("scaled longword subtract wrong");

  a_quad_diff: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_quad_issue |=> wr_en_o && result_o == $past(operand_a_i + ~b_val + 64'h1))
    else $error("quadword difference wrong");

  a_quad_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_quad_issue ##0 ovf_q |=> wr_en_o && result_o == $past(operand_a_i - b_val))
    else $error("quadword overflow result not written");

  a_s4_quad: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SCALED4_SUB_QUAD
    |=> result_o == $past({operand_a_i[61:0], 2'h0} - b_val))
    else $error("scaled by 4 quad subtract wrong");

  a_and_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_AND |=> result_o == ($past(operand_a_i) & $past(b_val)))
    else $error("and result wrong");

  a_or_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_INCLUSIVE_OR |=> result_o == ($past(operand_a_i) | $past(b_val)))
    else $error("or result wrong");

  a_xor_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_XOR |=> result_o == ($past(operand_a_i) ^ $past(b_val)))
    else $error("xor result wrong");

  a_andc_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_AND_COMPLEMENT |=> result_o == ($past(operand_a_i) & ~$past(b_val)))
    else $error("and complement result wrong");

  a_orc_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_OR_COMPLEMENT |=> result_o == ($past(operand_a_i) | ~$past(b_val)))
    else $error("or complement result wrong");

  a_xnor_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_XNOR_OP |=> result_o == ~($past(operand_a_i) ^ $past(b_val)))
    else $error("xnor result wrong");

  a_cmov_take: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cmov_issue ##0 cond_ok |=> wr_en_o && result_o == $past(b_val))
    else $error("true conditional move lost");

  a_cmov_le: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cmov_issue ##0 cond_i == isa_pkg::CND_LE
    |=> wr_en_o == $past($signed(operand_a_i) <= 64'sh0))
    else $error("less or equal test wrong");

  a_cmov_gt: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cmov_issue ##0 cond_i == isa_pkg::CND_GT
    |=> wr_en_o == $past($signed(operand_a_i) > 64'sh0))
    else $error("greater than test wrong");

  a_cmov_lbs: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cmov_issue ##0 cond_i == isa_pkg::CND_LBS
    |=> wr_en_o == $past(operand_a_i[0]))
    else $error("low bit set test wrong");

  a_sll_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SHIFT_LEFT_ZERO_FILL
    |=> result_o == $past(operand_a_i << b_val[5:0]))
    else $error("left shift wrong");

  a_srl_res: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SHIFT_RIGHT_ZERO_FILL
    |=> result_o == $past(operand_a_i >> b_val[5:0]))
    else $error("right shift wrong");

  a_sra_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && op_i == isa_pkg::OP_SHIFT_RIGHT_SIGN_FILL
    |=> result_o == $past($signed(operand_a_i) >>> b_val[5:0]))
    else $error("sign fill shift wrong");

  a_lit_zext: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && use_lit_i && op_i == isa_pkg::OP_INCLUSIVE_OR && operand_a_i == 64'h0
    |=> result_o == {56'h0, $past(literal_i)})
    else $error("literal not zero extended");

  a_trap_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
    valid_i && !trap_en_i |=> !ovf_trap_o)
    else $error("trap without enable");
endmodule : isa_alu

/* testbench/test_integer_sub_logic_shift_alu.sv */
// Purpose: Self-checking bench for the subtract/logic/shift datapath
// Assumes: Result, write strobe and trap appear one cycle after issue
// Notes:   Inputs change on the falling edge, outputs sampled there too
`timescale 1ns/1ps
module test_integer_sub_logic_shift_alu;
  logic               core_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               valid_i = 1'b0;
  isa_pkg::isa_op_t   op_i = isa_pkg::OP_AND;
  isa_pkg::isa_cond_t cond_i = isa_pkg::CND_EQ;
  logic               trap_en_i = 1'b0;
  logic               use_lit_i = 1'b0;
  logic [7:0]         literal_i = 8'h00;
  logic [63:0]        operand_a_i = 64'h0;
  logic [63:0]        operand_b_i = 64'h0;
  logic [4:0]         dest_i = 5'h00;
  logic               wr_en_o;
  logic [4:0]         dest_o;
  logic [63:0]        result_o;
  logic               ovf_trap_o;
  logic [63:0]        last_res = 64'h0;
  int                 fails = 0;
  int                 cmp_count = 0;
  localparam logic [63:0] ONES = 64'hffffffffffffffff;

  always #4 core_clk_i = ~core_clk_i;

  isa_alu dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .valid_i(valid_i), .op_i(op_i),
    .cond_i(cond_i), .trap_en_i(trap_en_i), .use_lit_i(use_lit_i), .literal_i(literal_i),
    .operand_a_i(operand_a_i), .operand_b_i(operand_b_i), .dest_i(dest_i),
    .wr_en_o(wr_en_o), .dest_o(dest_o), .result_o(result_o), .ovf_trap_o(ovf_trap_o));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Issue one instruction, then judge the registered answer one cycle on
  task automatic step(input isa_pkg::isa_op_t op, input logic [63:0] a, b, eres,
                      input logic ewr, etrap, trap, lit_sel = 1'b0,
                      input logic [7:0] lit = 8'h00,
                      input isa_pkg::isa_cond_t cnd = isa_pkg::CND_EQ);
    valid_i = 1'b1;
    op_i = op;
    cond_i = cnd;
    trap_en_i = trap;
    use_lit_i = lit_sel;
    literal_i = lit;
    operand_a_i = a;
    operand_b_i = b;
    dest_i = dest_i + 5'h01;
    @(negedge core_clk_i);
    chk({63'h0, wr_en_o}, {63'h0, ewr});
    chk(result_o, ewr ? eres : last_res);
    chk({63'h0, ovf_trap_o}, {63'h0, etrap});
    chk({59'h0, dest_o}, {59'h0, dest_i});
    if (ewr) last_res = eres;
  endtask : step

  task automatic idle();
    valid_i = 1'b0;
    @(negedge core_clk_i);
    chk({62'h0, wr_en_o, ovf_trap_o}, 64'h0);
    chk(result_o, last_res);
  endtask : idle

  task automatic t_mulh();
    step(isa_pkg::OP_MUL_UNSIGNED_UPPER_HALF, ONES, ONES, 64'hfffffffffffffffe, 1, 0, 1);
    step(isa_pkg::OP_MUL_UNSIGNED_UPPER_HALF, 64'h100000000, 64'h100000000,
         64'h1, 1, 0, 1);
  endtask : t_mulh

  task automatic t_sub_long();
    step(isa_pkg::OP_SUB_LONG, 64'hdead000000000001, 64'hbeef000000000002, ONES, 1, 0, 1);
    step(isa_pkg::OP_SUB_LONG, 64'h80000000, 64'h1, 64'h7fffffff, 1, 1, 1);
    step(isa_pkg::OP_SUB_LONG, 64'h8000000000000000, 64'h1, ONES, 1, 0, 1);
    step(isa_pkg::OP_SUB_LONG, 64'h80000000, 64'h1, 64'h7fffffff, 1, 0, 0);
    step(isa_pkg::OP_SCALED4_SUB_LONG, 64'h1, 64'h5, ONES, 1, 0, 1);
    step(isa_pkg::OP_SCALED8_SUB_LONG, 64'hf000000010000000, 64'h0,
         64'hffffffff80000000, 1, 0, 1);
    step(isa_pkg::OP_SCALED4_SUB_LONG, 64'h20000000, 64'h1, 64'h7fffffff, 1, 0, 1);
  endtask : t_sub_long

  task automatic t_sub_quad();
    step(isa_pkg::OP_SUB_QUAD, 64'h1, 64'h2, ONES, 1, 0, 1);
    idle();
    step(isa_pkg::OP_SUB_QUAD, 64'h8000000000000000, 64'h1,
         ~64'h8000000000000000, 1, 1, 1);
    step(isa_pkg::OP_SUB_QUAD, ~64'h8000000000000000, ONES,
         64'h8000000000000000, 1, 1, 1);
    step(isa_pkg::OP_SUB_QUAD, 64'h0, 64'h8000000000000000,
         64'h8000000000000000, 1, 0, 0);
    step(isa_pkg::OP_SUB_QUAD, 64'h0, 64'h1, ONES, 1, 0, 1);
    step(isa_pkg::OP_SCALED4_SUB_QUAD, 64'h4000000000000000, 64'h1, ONES, 1, 0, 1);
    step(isa_pkg::OP_SCALED8_SUB_QUAD, 64'h3, 64'h4, 64'h14, 1, 0, 1);
    step(isa_pkg::OP_SCALED8_SUB_QUAD, 64'h1000000000000000, 64'h1,
         ~64'h8000000000000000, 1, 0, 1);
    idle();
  endtask : t_sub_quad

  task automatic t_bool();
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] e;
    a = 64'hff00ff00f0f0cccc;
    b = 64'h0ff00ff0aaaa3333;
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: e = a & b;
        1: e = a & ~b;
        2: e = a | b;
        3: e = a | ~b;
        4: e = a ^ b;
        default: e = a ^ ~b;
      endcase
      step(isa_pkg::isa_op_t'(5'h07 + i[4:0]), a, b, e, 1, 0, 1);
    end
    step(isa_pkg::OP_INCLUSIVE_OR, 64'h0, 64'hffffffffffffff00, 64'ha5, 1, 0, 0, 1, 8'ha5);
  endtask : t_bool

  // Back-to-back moves; a false test must leave the old result standing
  task automatic t_cmov();
    logic [63:0] av [4] = '{64'h0, ONES, 64'h2, 64'h3};
    logic [63:0] b;
    logic        t;
    for (int c = 0; c < 8; c++) begin
      for (int j = 0; j < 4; j++) begin
        case (c)
          0: t = av[j] == 64'h0;
          1: t = av[j] != 64'h0;
          2: t = $signed(av[j]) < 0;
          3: t = $signed(av[j]) <= 0;
          4: t = $signed(av[j]) > 0;
          5: t = $signed(av[j]) >= 0;
          6: t = !av[j][0];
          default: t = av[j][0];
        endcase
        b = 64'h5a5a000000000000 + 64'(c * 4 + j);
        step(isa_pkg::OP_COND_MOVE, av[j], b, b, t, 0, 1, 0, 8'h00,
             isa_pkg::isa_cond_t'(c));
      end
    end
  endtask : t_cmov

  task automatic t_shift();
    logic [63:0] a;
    logic [63:0] e;
    logic [5:0]  cnt [4] = '{6'h00, 6'h01, 6'h3f, 6'h21};
    a = 64'h8000000000000001;
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 4; j++) begin
        case (k)
          0: e = a << cnt[j];
          1: e = a >> cnt[j];
          default: e = $signed(a) >>> cnt[j];
        endcase
        step(isa_pkg::isa_op_t'(5'h0e + k[4:0]), a, 64'hffffffffffffffc0 | 64'(cnt[j]),
             e, 1, 0, 1);
      end
    end
    step(isa_pkg::OP_SHIFT_RIGHT_SIGN_FILL, a, 64'h0, 64'hf800000000000000,
         1, 0, 0, 1, 8'h44);
  endtask : t_shift

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk_i);
    fails++;
    results();
  end

  initial begin
    repeat (2) @(negedge core_clk_i);
    chk({57'h0, wr_en_o, ovf_trap_o, dest_o}, 64'h0);
    chk(result_o, 64'h0);
    rst_i = 1'b0;
    t_mulh();
    t_sub_long();
    t_sub_quad();
    t_bool();
    t_cmov();
    t_shift();
    idle();
    results();
  end
endmodule : test_integer_sub_logic_shift_alu
